// ===== hw/ucr_top.sv
// USB module control register with APB slave and pin controls.
// Assumes APB master on clock_in; USB line states arrive asynchronously.
// Notes on behaviour
// - Bits 15 to 7 and bit 4 read zero; writes ignored.
// - Live single-ended-zero flag follows the bus state.
// - Packet transfer disable set stops token and packet processing.
// - Hardware sets packet transfer disable on a received setup token.
// - Host mode enable turns on host mode and D+/D- pull-downs.
// - Resume enable drives resume signalling on the bus.
// - Writing one to pointer reset returns all pointers to even banks.
// - Module enable enables the module and, with host mode enable clear, the D+ pull-up.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ns
module ucr_top #(
	parameter int NUM_PP = ucr_pkg::UCR_NUM_PP
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic dp_in,
	input wire logic dm_in,
	input wire logic setup_token_in,
	input wire logic [NUM_PP-1:0] pp_toggle_in,
	output logic [NUM_PP-1:0] pp_odd_out,
	output logic sie_enable_out,
	output logic host_mode_out,
	output logic resume_drive_out,
	output logic module_enable_out,
	output ucr_pkg::ucr_pull_t pull_out
);
	ucr_pkg::ucr_ctrl_t ctrl_q;
	ucr_pkg::ucr_ctrl_t ctrl_d;
	logic [1:0] dp_sync_q;
	logic [1:0] dm_sync_q;
	logic se0_q;
	logic [31:0] rdata_d;

	// Line inputs come from pins, so each passes two flops first.
	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			// D+ resets to its idle J level so no false zero follows reset.
			dp_sync_q <= 2'h3;
			dm_sync_q <= 2'h0;
			se0_q <= 1'b0;
		end else begin
			dp_sync_q <= {dp_sync_q[0], dp_in};
			dm_sync_q <= {dm_sync_q[0], dm_in};
			se0_q <= ~dp_sync_q[1] & ~dm_sync_q[1];
		end
	end

	wire access_w = psel_in & penable_in;
	wire wr_ctrl_w = access_w & pwrite_in &
		(paddr_in == ucr_pkg::UCR_CTRL_ADDR);
	wire wr_pp_w = access_w & pwrite_in &
		(paddr_in == ucr_pkg::UCR_PPTR_ADDR);
	wire hit_w = (paddr_in == ucr_pkg::UCR_CTRL_ADDR) |
		(paddr_in == ucr_pkg::UCR_PPTR_ADDR);
	wire pp_clear_w = wr_ctrl_w & pwdata_in[ucr_pkg::UCR_PPRST_BIT];
	wire [15:0] wmask_w = pwdata_in[15:0] & ucr_pkg::UCR_WR_MASK;
	wire [15:0] ctrl_rd_w = {9'h000, se0_q, ctrl_q.packet_transfer_disable,
		1'b0, ctrl_q.host_mode_enable, ctrl_q.resume_enable, 1'b0,
		ctrl_q.module_enable};

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl_w) begin
			ctrl_d.host_mode_enable = wmask_w[ucr_pkg::UCR_HOST_MODE_ENABLE_BIT];
			ctrl_d.resume_enable = wmask_w[ucr_pkg::UCR_RESUME_BIT];
			ctrl_d.module_enable = wmask_w[ucr_pkg::UCR_MODEN_BIT];
			ctrl_d.packet_transfer_disable = wmask_w[ucr_pkg::UCR_PACKET_TRANSFER_DISABLE_BIT];
		end
		// A setup token beats a software clear in the same cycle.
		if (setup_token_in)
			ctrl_d.packet_transfer_disable = 1'b1;
	end

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (paddr_in == ucr_pkg::UCR_CTRL_ADDR)
			rdata_d = {16'h0000, ctrl_rd_w};
		else if (paddr_in == ucr_pkg::UCR_PPTR_ADDR)
			rdata_d = 32'(pp_odd_out);
	end

	always_ff @(posedge clock_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl_q.host_mode_enable <=
				ucr_pkg::UCR_CTRL_RESET[ucr_pkg::UCR_HOST_MODE_ENABLE_BIT];
			ctrl_q.resume_enable <=
				ucr_pkg::UCR_CTRL_RESET[ucr_pkg::UCR_RESUME_BIT];
			ctrl_q.module_enable <=
				ucr_pkg::UCR_CTRL_RESET[ucr_pkg::UCR_MODEN_BIT];
			ctrl_q.packet_transfer_disable <=
				ucr_pkg::UCR_CTRL_RESET[ucr_pkg::UCR_PACKET_TRANSFER_DISABLE_BIT];
			prdata_out <= 32'h0000_0000;
		end else begin
			ctrl_q <= ctrl_d;
			if (psel_in & ~penable_in & ~pwrite_in)
				prdata_out <= rdata_d;
		end
	end

	assign pready_out = 1'b1;
	assign pslverr_out = access_w & ~hit_w;

	ucr_pingpong #(
		.NUM_PP(NUM_PP)
	) u_pp (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.clear_in(pp_clear_w),
		.toggle_in(pp_toggle_in & {NUM_PP{sie_enable_out}}),
		.odd_out(pp_odd_out)
	);

	// Pin controls are combinational from flops; they follow the register.
	assign sie_enable_out = ctrl_q.module_enable &
		~ctrl_q.packet_transfer_disable;
	assign host_mode_out = ctrl_q.host_mode_enable;
	assign resume_drive_out = ctrl_q.resume_enable;
	assign module_enable_out = ctrl_q.module_enable;
	assign pull_out.pulldown_dp = ctrl_q.host_mode_enable;
	assign pull_out.pulldown_dm = ctrl_q.host_mode_enable;
	assign pull_out.pullup_dp = ctrl_q.module_enable &
		~ctrl_q.host_mode_enable;

	se0_flag_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(~dp_in & ~dm_in)[*4] |-> ctrl_rd_w[ucr_pkg::UCR_SE0_BIT])
		else $error("se0 flag not set");
	setup_sets_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		setup_token_in |=> ctrl_q.packet_transfer_disable)
		else $error("setup did not set disable");
	stop_sie_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		ctrl_q.packet_transfer_disable |-> ~sie_enable_out)
		else $error("engine runs while disabled");
	// Checks the effect on the engine: no pointer moves while disabled, except on a pointer reset write.
	pp_frozen_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		ctrl_q.packet_transfer_disable && !pp_clear_w |=>
		$stable(pp_odd_out))
		else $error("pointer moved while disabled");
	pp_clear_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		pp_clear_w |=> pp_odd_out == '0)
		else $error("pointers not reset to even");
	pp_keep_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		(wr_pp_w || (wr_ctrl_w && !pwdata_in[ucr_pkg::UCR_PPRST_BIT])) &&
		pp_toggle_in == '0 |=> $stable(pp_odd_out))
		else $error("pointers changed without reset");
	unimpl_zero_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		psel_in && !penable_in && !pwrite_in &&
		paddr_in == ucr_pkg::UCR_CTRL_ADDR |=>
		prdata_out[31:7] == 25'h0000000 && !prdata_out[4] &&
		!prdata_out[1])
		else $error("unimplemented bits read nonzero");
	host_pull_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		wr_ctrl_w && !setup_token_in |=> pull_out.pulldown_dm ==
		$past(pwdata_in[ucr_pkg::UCR_HOST_MODE_ENABLE_BIT]))
		else $error("host pull-down mismatch");
	resume_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		wr_ctrl_w |=> resume_drive_out ==
		$past(pwdata_in[ucr_pkg::UCR_RESUME_BIT]))
		else $error("resume drive mismatch");
	enable_a: assert property (
		@(posedge clock_in) disable iff (rst_in)
		wr_ctrl_w |=> module_enable_out ==
		$past(pwdata_in[ucr_pkg::UCR_MODEN_BIT]))
		else $error("module enable mismatch");
	setup_c: cover property (@(posedge clock_in) setup_token_in ##1
		wr_ctrl_w);
	setup_wr_c: cover property (@(posedge clock_in) setup_token_in &&
		wr_ctrl_w);
	pp_c: cover property (@(posedge clock_in) pp_clear_w);
	host_c: cover property (@(posedge clock_in) host_mode_out ##1
		resume_drive_out);
endmodule

// ===== hw/ucr_pkg.sv
// Package for the USB module control register block.
// Assumes a 32-bit APB master and a single 100 MHz clock domain.
package ucr_pkg;
	localparam logic [11:0] UCR_CTRL_ADDR = 12'h000;
	localparam logic [11:0] UCR_PPTR_ADDR = 12'h004;
	localparam int UCR_SE0_BIT = 6;
	localparam int UCR_PACKET_TRANSFER_DISABLE_BIT = 5;
	localparam int UCR_HOST_MODE_ENABLE_BIT = 3;
	localparam int UCR_RESUME_BIT = 2;
	localparam int UCR_PPRST_BIT = 1;
	localparam int UCR_MODEN_BIT = 0;
	localparam logic [15:0] UCR_CTRL_RESET = 16'h0000;
	localparam logic [15:0] UCR_WR_MASK = 16'h002f;
	localparam int UCR_NUM_PP = 16;

	typedef struct packed {
		logic host_mode_enable;
		logic resume_enable;
		logic module_enable;
		logic packet_transfer_disable;
	} ucr_ctrl_t;

	typedef struct packed {
		logic pullup_dp;
		logic pulldown_dp;
		logic pulldown_dm;
	} ucr_pull_t;
endpackage

// ===== hw/ucr_pingpong.sv
// Ping-pong buffer pointer bank, one toggling bit per pointer.
// Assumes toggle requests from the engine on the same clock.
`timescale 1ns/1ns
module ucr_pingpong #(
	parameter int NUM_PP = ucr_pkg::UCR_NUM_PP
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic [NUM_PP-1:0] toggle_in,
	output logic [NUM_PP-1:0] odd_out
);
	genvar i;
	generate
		for (i = 0; i < NUM_PP; i++) begin : g_pp
			always_ff @(posedge clock_in or posedge rst_in) begin
				if (rst_in)
					odd_out[i] <= 1'b0;
				else if (clear_in)
					odd_out[i] <= 1'b0;
				else if (toggle_in[i])
					odd_out[i] <= ~odd_out[i];
			end
		end
	endgenerate
endmodule

// ===== testbench/ucr_bus_partner.sv
// Model of the far party on the USB lines, driving D+ and D-.
// Assumes the block samples the line levels through its own flops.
`timescale 1ns/1ns
module ucr_bus_partner (
	input wire logic se0_in,
	input wire logic k_in,
	output logic dp_out,
	output logic dm_out
);
	// Idle is the J state, K swaps the lines, a single-ended zero pulls
	// both low.
	assign dp_out = ~se0_in & ~k_in;
	assign dm_out = ~se0_in & k_in;
endmodule

// ===== testbench/usb_control_register_bench.sv
// Self-checking bench for the USB module control register block.
// Assumes the APB slave answers without wait states and one clock.
`timescale 1ns/1ns
module usb_control_register_bench;
	logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [11:0] pa = 12'h000;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic rdy, err, er, tok = 1'b0, se0 = 1'b0, k = 1'b0, dp, dm;
	logic sie, host, res, men;
	logic [15:0] tgl = 16'h0000, odd;
	ucr_pkg::ucr_pull_t pull;
	int error_cnt = 0, check_count = 0, cyc = 0;
	always #5 clk = ~clk;
	ucr_top uut (.clock_in(clk), .rst_in(rst), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd),
		.prdata_out(prd), .pready_out(rdy), .pslverr_out(err), .dp_in(dp),
		.dm_in(dm), .setup_token_in(tok), .pp_toggle_in(tgl),
		.pp_odd_out(odd), .sie_enable_out(sie), .host_mode_out(host),
		.resume_drive_out(res), .module_enable_out(men), .pull_out(pull));
	ucr_bus_partner bus (.se0_in(se0), .k_in(k), .dp_out(dp),
		.dm_out(dm));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk);
		{psel, pen, pwr, pa, pwd} <= {1'b1, 1'b0, w, a, d};
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd = prd;
		er = err;
		{psel, pen} <= 2'b00;
	endtask
	task automatic rdchk(input logic [31:0] e);
		apb(1'b0, ucr_pkg::UCR_CTRL_ADDR, 32'h0);
		chk(rd, e);
		chk(er, 32'h0);
	endtask
	// Packs the levels as enable, host, resume, module, pull-up, pull-downs.
	task automatic outs(input logic [6:0] e);
		@(negedge clk);
		chk({sie, host, res, men, pull}, e);
	endtask
	task automatic pulse(input logic t, input logic [15:0] g);
		@(posedge clk);
		{tok, tgl} <= {t, g};
		@(posedge clk);
		{tok, tgl} <= 17'h0;
		@(negedge clk);
	endtask
	task automatic t_mask;
		outs(7'h00);
		rdchk(32'h0);
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'hffff_ffff);
		outs(7'h3b);
		rdchk(32'h2d);
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_000c);
		outs(7'h33);
		apb(1'b0, 12'h008, 32'h0);
		chk(er, 32'h1);
		chk(rd, 32'h0);
		$display("test mask done");
	endtask
	task automatic t_pp;
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_0001);
		outs(7'h4c);
		pulse(1'b0, 16'h00a5);
		chk(odd, 32'h00a5);
		apb(1'b0, ucr_pkg::UCR_PPTR_ADDR, 32'h0);
		chk(rd, 32'h00a5);
		apb(1'b1, ucr_pkg::UCR_PPTR_ADDR, 32'hffff_ffff);
		outs(7'h4c);
		chk(odd, 32'h00a5);
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_0003);
		outs(7'h4c);
		chk(odd, 32'h0);
		rdchk(32'h01);
		$display("test pointers done");
	endtask
	task automatic t_setup;
		pulse(1'b1, 16'h0);
		rdchk(32'h21);
		outs(7'h0c);
		pulse(1'b0, 16'h0001);
		chk(odd, 32'h0);
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_0001);
		outs(7'h4c);
		// The token lands on the clearing write's access edge; it must win.
		@(posedge clk);
		{psel, pen, pwr, pa, pwd} <=
			{1'b1, 1'b0, 1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_0001};
		@(posedge clk);
		{pen, tok} <= 2'b11;
		do @(posedge clk); while (rdy !== 1'b1);
		{psel, pen, tok} <= 3'b000;
		rdchk(32'h21);
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_0001);
		outs(7'h4c);
		$display("test setup done");
	endtask
	// The flag trails the lines by three cycles of synchronising flops.
	task automatic t_se0;
		@(posedge clk);
		se0 <= 1'b1;
		repeat (6) @(posedge clk);
		rdchk(32'h41);
		se0 <= 1'b0;
		repeat (6) @(posedge clk);
		rdchk(32'h01);
		k <= 1'b1;
		repeat (6) @(posedge clk);
		rdchk(32'h01);
		k <= 1'b0;
		$display("test se0 done");
	endtask
	// A reset in mid-run must clear the register and every pointer.
	task automatic t_rst;
		apb(1'b1, ucr_pkg::UCR_CTRL_ADDR, 32'h0000_000d);
		outs(7'h7b);
		pulse(1'b0, 16'h0003);
		chk(odd, 32'h0003);
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		outs(7'h00);
		chk(odd, 32'h0);
		@(posedge clk);
		rst <= 1'b0;
		rdchk(32'h0);
		$display("test reset done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			print_verdict();
		end
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_mask();
		t_pp();
		t_setup();
		t_se0();
		t_rst();
		print_verdict();
	end
endmodule
